// [inc/capstan_pkg.sv]
// Shared constants, types and functions of the capstan speed regulator.
package capstan_pkg;
  localparam int PCLK_HZ = 125_000_000;
  localparam int REF_HZ = 2_000_000;
  localparam int PCLK_MHZ = PCLK_HZ / 1_000_000;
  localparam int REF_MHZ = REF_HZ / 1_000_000;
  localparam int REF_CNT_W = 9;
  localparam int INTERVAL_M3_US = 125;
  localparam int INTERVAL_M5_US = 75;
  localparam int INTERVAL_M7_US = 47;
  localparam logic [REF_CNT_W-1:0] REF_LIM_M3 = REF_CNT_W'(INTERVAL_M3_US * REF_MHZ);
  localparam logic [REF_CNT_W-1:0] REF_LIM_M5 = REF_CNT_W'(INTERVAL_M5_US * REF_MHZ);
  localparam logic [REF_CNT_W-1:0] REF_LIM_M7 = REF_CNT_W'(INTERVAL_M7_US * REF_MHZ);
  localparam logic [1:0] SPEED_M3 = 2'h0;
  localparam logic [1:0] SPEED_M5 = 2'h1;
  localparam logic [1:0] SPEED_M7 = 2'h2;
  localparam int GO_LAG_NS = 1000;
  localparam int GO_LAG_CYC = (GO_LAG_NS * PCLK_MHZ + 999) / 1000;
  localparam int SHOT_A_NS = 2000;
  localparam int SHOT_A_CYC = (SHOT_A_NS * PCLK_MHZ + 999) / 1000;
  localparam int SHOT_B_NS = 1000;
  localparam int SHOT_B_CYC = (SHOT_B_NS * PCLK_MHZ + 999) / 1000;
  localparam int SHOT_W = 9;
  localparam int DUTY_WINDOW = 24;
  localparam int DUTY_NORMAL_MAX = 7;
  localparam int DUTY_MARGINAL_MAX = 12;
  localparam int DUTY_CNT_W = 5;
  localparam int APB_ADDR_W = 12;
  localparam logic [APB_ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [APB_ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [APB_ADDR_W-1:0] REG_PERIOD = 12'h008;
  localparam logic [APB_ADDR_W-1:0] REG_DUTY = 12'h00C;
  localparam int CTRL_SPEED_LSB = 0;
  localparam int CTRL_HSREW_BIT = 2;
  localparam logic [1:0] CTRL_SPEED_RST = 2'h0;
  localparam logic CTRL_HSREW_RST = 1'h0;
  localparam int ST_FAST_BIT = 0;
  localparam int ST_ACCEL_BIT = 1;
  localparam int ST_GO_BIT = 2;
  localparam int ST_INHIBIT_BIT = 3;
  localparam int ST_DUTY_LSB = 4;
  localparam int DUTY_LAST_LSB = 0;
  localparam int DUTY_WIN_LSB = 8;

  typedef enum logic [1:0] {DUTY_NORMAL, DUTY_MARGINAL, DUTY_FAILING} duty_t;

  function automatic logic [REF_CNT_W-1:0] ref_limit(input logic [1:0] sel);
    logic [REF_CNT_W-1:0] lim;
    case (sel)
      SPEED_M5: lim = REF_LIM_M5;
      SPEED_M7: lim = REF_LIM_M7;
      default: lim = REF_LIM_M3;
    endcase
    return lim;
  endfunction

  function automatic duty_t duty_class(input logic [DUTY_CNT_W-1:0] d);
    duty_t c;
    if (d <= DUTY_CNT_W'(DUTY_NORMAL_MAX)) begin
      c = DUTY_NORMAL;
    end else if (d <= DUTY_CNT_W'(DUTY_MARGINAL_MAX)) begin
      c = DUTY_MARGINAL;
    end else begin
      c = DUTY_FAILING;
    end
    return c;
  endfunction
endpackage

// [inc/capstan_if.sv]
// Pulse streams and interval judgement passed between the regulator's modules.
`timescale 1ns/1ns
interface capstan_if;
  logic pulse_a;
  logic pulse_b;
  logic [1:0] speed_sel;
  logic fast;
  logic period_done;
  logic period_drive;
  logic [capstan_pkg::REF_CNT_W-1:0] period;
  modport shaper (output pulse_a, output pulse_b);
  modport judge (input pulse_a, input pulse_b, input speed_sel, output fast,
    output period_done, output period_drive, output period);
  modport ctrl (input fast, input period_done, input period_drive, input period,
    output speed_sel);
endinterface

// [design/capstan_pulse_shaper.sv]
// Tachometer input synchroniser and the two one-shots that form the A and B streams.
`timescale 1ns/1ns
module capstan_pulse_shaper #(
  parameter int SHOT_A_CYC = capstan_pkg::SHOT_A_CYC,
  parameter int SHOT_B_CYC = capstan_pkg::SHOT_B_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tach_in,
  capstan_if.shaper cp
);
  localparam int SW = capstan_pkg::SHOT_W;
  typedef struct packed {
    logic [2:0] sync;
    logic clean;
    logic [SW-1:0] shot_a;
    logic [SW-1:0] shot_b;
    logic pa;
    logic pb;
  } shaper_t;
  shaper_t st_reg;
  shaper_t st_next;
  logic rise;

  always_comb begin
    st_next = st_reg;
    rise = st_reg.sync[1] & st_reg.sync[2] & ~st_reg.clean;
    st_next.sync = {st_reg.sync[1:0], tach_in};
    if (st_reg.sync[1] == st_reg.sync[2]) begin
      st_next.clean = st_reg.sync[2];
    end
    if (rise) begin
      st_next.shot_a = SW'(SHOT_A_CYC);
      st_next.shot_b = SW'(SHOT_B_CYC);
    end else begin
      if (st_reg.shot_a != '0) begin
        st_next.shot_a = st_reg.shot_a - 1'b1;
      end
      if (st_reg.shot_b != '0) begin
        st_next.shot_b = st_reg.shot_b - 1'b1;
      end
    end
    st_next.pa = (st_next.shot_a != '0);
    st_next.pb = (st_next.shot_b != '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cp.pulse_a = st_reg.pa;
  assign cp.pulse_b = st_reg.pb;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SHOT_FIRE: assert property (rise |=> cp.pulse_a && cp.pulse_b)
    else $error("One-shots did not fire on a tachometer edge.");
endmodule

// [design/capstan_interval_judge.sv]
// Reference counter on a 2 MHz tick that judges each capstan pulse interval.
`timescale 1ns/1ns
module capstan_interval_judge (
  input wire logic pclk,
  input wire logic presetn,
  capstan_if.judge cp
);
  localparam int AW = 7;
  localparam int RW = capstan_pkg::REF_CNT_W;
  typedef struct packed {
    logic [AW-1:0] acc;
    logic tick;
    logic [RW-1:0] ref_cnt;
    logic ovf;
    logic fast;
    logic drive_seen;
    logic [RW-1:0] period;
    logic done;
    logic drv;
    logic a_prev;
    logic b_prev;
  } judge_t;
  judge_t st_reg;
  judge_t st_next;
  logic rise_a;
  logic rise_b;
  logic [AW-1:0] acc_sum;
  logic [RW-1:0] limit;
  logic [RW-1:0] cnt_inc;

  always_comb begin
    st_next = st_reg;
    rise_a = cp.pulse_a & ~st_reg.a_prev;
    rise_b = cp.pulse_b & ~st_reg.b_prev;
    limit = capstan_pkg::ref_limit(cp.speed_sel);
    acc_sum = st_reg.acc + AW'(capstan_pkg::REF_MHZ);
    cnt_inc = st_reg.ref_cnt + 1'b1;
    st_next.a_prev = cp.pulse_a;
    st_next.b_prev = cp.pulse_b;
    st_next.done = 1'b0;
    st_next.tick = (acc_sum >= AW'(capstan_pkg::PCLK_MHZ));
    st_next.acc = st_next.tick ? acc_sum - AW'(capstan_pkg::PCLK_MHZ) : acc_sum;
    if (!st_reg.fast) begin
      st_next.drive_seen = 1'b1;
    end
    if (st_reg.tick && !st_reg.ovf) begin
      st_next.ref_cnt = cnt_inc;
      if (cnt_inc >= limit) begin
        st_next.ovf = 1'b1;
        st_next.fast = 1'b0;
      end
    end
    if (rise_a) begin
      st_next.fast = ~st_reg.ovf;
      st_next.period = st_reg.ovf ? limit : st_reg.ref_cnt;
      st_next.drv = st_reg.drive_seen | ~st_reg.fast;
      st_next.done = 1'b1;
    end
    if (rise_b) begin
      st_next.ref_cnt = '0;
      st_next.ovf = 1'b0;
      st_next.drive_seen = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cp.fast = st_reg.fast;
  assign cp.period_done = st_reg.done;
  assign cp.period_drive = st_reg.drv;
  assign cp.period = st_reg.period;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_REF_TICK: assert property (st_reg.tick |=> (!st_reg.tick) [*8])
    else $error("Reference tick runs faster than 2 MHz.");
  AST_FAST_EARLY: assert property ((rise_a && !st_reg.ovf) |=> st_reg.fast)
    else $error("Early pulse did not mark the capstan fast.");
  AST_SLOW_OVF: assert property ($rose(st_reg.ovf) |-> !st_reg.fast)
    else $error("Overflow did not mark the capstan slow.");
  AST_OVF_LIMIT: assert property ($rose(st_reg.ovf) |-> st_reg.ref_cnt >= $past(limit))
    else $error("Reference counter overflowed short of its limit.");
  AST_RESTART: assert property (rise_b |=> st_reg.ref_cnt == '0 && !st_reg.ovf)
    else $error("Reference counter did not restart on a pulse.");
endmodule

// [design/capstan_speed_regulator.sv]
// Capstan speed regulator top: APB registers, move sequencing, drive and duty tracking.
//
// Behaviour
// - Pulse intervals are timed against a counter stepped at 2 MHz.
// - A pulse arriving before counter overflow marks the capstan fast.
// - Counter overflow before the next pulse marks the capstan slow.
// - Drive accelerates while not fast and coasts while fast.
// - Reference interval is 125, 75 or 47 us by selected speed variant.
// - A drive share near one in four periods is classed normal.
// - One period is the time between two successive capstan pulses.
// - A drive share near one to two periods is classed marginal.
// - A drive share near two to one periods is classed failing.
// - Write inhibit rises at the falling edge of the move request.
// - Capstan go drops shortly after write inhibit rises, never earlier.
// - Each tachometer pulse fires two one-shots giving the A and B streams.
// - Regulate speed normally; high-speed rewind drives at full speed.
`timescale 1ns/1ns
module capstan_speed_regulator #(
  parameter int SHOT_A_CYC = capstan_pkg::SHOT_A_CYC,
  parameter int SHOT_B_CYC = capstan_pkg::SHOT_B_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [capstan_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tach_in,
  input wire logic move_req,
  output logic write_inhibit,
  output logic capstan_go,
  output logic drive_accel,
  output logic drive_coast
);
  // ----------------------------------------------------------------
  // Local sizes and state.
  // ----------------------------------------------------------------
  localparam int DW = capstan_pkg::DUTY_CNT_W;
  localparam int LW = 8;
  localparam int GO_DROP_MAX = 130;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_LAG} seq_t;

  typedef struct packed {
    logic [2:0] mv_sync;
    logic mv_clean;
    logic mv_prev;
    logic [1:0] speed;
    logic hs_rew;
    seq_t seq;
    logic [LW-1:0] lag;
    logic inhibit;
    logic go;
    logic accel;
    logic coast;
    logic [DW-1:0] win;
    logic [DW-1:0] drv;
    logic [DW-1:0] last_drv;
    capstan_pkg::duty_t duty;
    logic [31:0] rdata;
    logic err;
  } reg_state_t;

  reg_state_t st_reg;
  reg_state_t st_next;
  logic mv_rise;
  logic mv_fall;
  logic setup;
  logic access;
  logic counting;
  logic closing;
  logic [DW-1:0] d_sum;

  // ----------------------------------------------------------------
  // Pulse shaping and interval judgement.
  // ----------------------------------------------------------------
  capstan_if cp ();

  capstan_pulse_shaper #(
    .SHOT_A_CYC(SHOT_A_CYC),
    .SHOT_B_CYC(SHOT_B_CYC)
  ) u_shaper (
    .pclk(pclk),
    .presetn(presetn),
    .tach_in(tach_in),
    .cp(cp.shaper)
  );

  capstan_interval_judge u_judge (
    .pclk(pclk),
    .presetn(presetn),
    .cp(cp.judge)
  );

  assign cp.speed_sel = st_reg.speed;

  // ----------------------------------------------------------------
  // Move request edges, taken after the synchroniser.
  // ----------------------------------------------------------------
  assign mv_rise = st_reg.mv_clean & ~st_reg.mv_prev;
  assign mv_fall = st_reg.mv_prev & ~st_reg.mv_clean;

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    setup = psel & ~penable;
    access = psel & penable;
    counting = 1'b0;
    closing = 1'b0;
    d_sum = '0;

    st_next.mv_sync = {st_reg.mv_sync[1:0], move_req};
    if (st_reg.mv_sync[1] == st_reg.mv_sync[2]) begin
      st_next.mv_clean = st_reg.mv_sync[2];
    end
    st_next.mv_prev = st_reg.mv_clean;

    case (st_reg.seq)
      SEQ_IDLE: begin
        if (mv_rise) begin
          st_next.seq = SEQ_RUN;
          st_next.go = 1'b1;
          st_next.inhibit = 1'b0;
          st_next.win = '0;
          st_next.drv = '0;
        end
      end
      SEQ_RUN: begin
        if (mv_fall) begin
          st_next.seq = SEQ_LAG;
          st_next.inhibit = 1'b1;
          st_next.lag = LW'(capstan_pkg::GO_LAG_CYC - 1);
        end
      end
      SEQ_LAG: begin
        if (mv_rise) begin
          st_next.seq = SEQ_RUN;
          st_next.inhibit = 1'b0;
        end else if (st_reg.lag == '0) begin
          st_next.seq = SEQ_IDLE;
          st_next.go = 1'b0;
        end else begin
          st_next.lag = st_reg.lag - 1'b1;
        end
      end
      default: begin
        st_next.seq = SEQ_IDLE;
        st_next.go = 1'b0;
        st_next.inhibit = 1'b1;
      end
    endcase

    // Full power in high-speed rewind, otherwise the fast flag decides.
    st_next.accel = st_reg.go & (st_reg.hs_rew | ~cp.fast);
    st_next.coast = st_reg.go & ~st_reg.hs_rew & cp.fast;

    // Drive periods are tallied over a fixed window of capstan periods.
    counting = cp.period_done & st_reg.go & ~st_reg.hs_rew;
    d_sum = st_reg.drv + DW'(cp.period_drive);
    closing = counting & (st_reg.win == DW'(capstan_pkg::DUTY_WINDOW - 1));
    if (closing) begin
      st_next.last_drv = d_sum;
      st_next.duty = capstan_pkg::duty_class(d_sum);
      st_next.win = '0;
      st_next.drv = '0;
    end else if (counting) begin
      st_next.win = st_reg.win + 1'b1;
      st_next.drv = d_sum;
    end

    // Read data and error are prepared in the setup phase.
    if (setup) begin
      st_next.rdata = '0;
      st_next.err = 1'b0;
      case (paddr)
        capstan_pkg::REG_CTRL: begin
          st_next.rdata[capstan_pkg::CTRL_SPEED_LSB +: 2] = st_reg.speed;
          st_next.rdata[capstan_pkg::CTRL_HSREW_BIT] = st_reg.hs_rew;
        end
        capstan_pkg::REG_STATUS: begin
          st_next.rdata[capstan_pkg::ST_FAST_BIT] = cp.fast;
          st_next.rdata[capstan_pkg::ST_ACCEL_BIT] = st_reg.accel;
          st_next.rdata[capstan_pkg::ST_GO_BIT] = st_reg.go;
          st_next.rdata[capstan_pkg::ST_INHIBIT_BIT] = st_reg.inhibit;
          st_next.rdata[capstan_pkg::ST_DUTY_LSB +: 2] = st_reg.duty;
        end
        capstan_pkg::REG_PERIOD: begin
          st_next.rdata[capstan_pkg::REF_CNT_W-1:0] = cp.period;
        end
        capstan_pkg::REG_DUTY: begin
          st_next.rdata[capstan_pkg::DUTY_LAST_LSB +: DW] = st_reg.last_drv;
          st_next.rdata[capstan_pkg::DUTY_WIN_LSB +: DW] = st_reg.win;
        end
        default: begin
          st_next.err = 1'b1;
        end
      endcase
    end

    // Only the control register takes writes; others ignore them.
    if (access && pwrite && !st_reg.err && paddr == capstan_pkg::REG_CTRL) begin
      st_next.speed = pwdata[capstan_pkg::CTRL_SPEED_LSB +: 2];
      st_next.hs_rew = pwdata[capstan_pkg::CTRL_HSREW_BIT];
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.speed <= capstan_pkg::CTRL_SPEED_RST;
      st_reg.hs_rew <= capstan_pkg::CTRL_HSREW_RST;
      st_reg.inhibit <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = access & st_reg.err;
  assign prdata = st_reg.rdata;
  assign write_inhibit = st_reg.inhibit;
  assign capstan_go = st_reg.go;
  assign drive_accel = st_reg.accel;
  assign drive_coast = st_reg.coast;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop;
    mv_fall && st_reg.seq == SEQ_RUN;
  endsequence

  sequence s_close;
    closing;
  endsequence

  AST_INHIBIT_ON_FALL: assert property (mv_fall |=> st_reg.inhibit)
    else $error("Write inhibit did not rise at the fall of move.");

  AST_GO_HOLDS: assert property (s_stop |=> st_reg.go [*8])
    else $error("Go dropped too soon after the fall of move.");

  AST_GO_BEHIND: assert property ($fell(st_reg.go) |-> $past(st_reg.inhibit, 8))
    else $error("Go dropped before write inhibit was active.");

  AST_GO_DROP_BOUND: assert property (
    s_stop |-> ##[1:GO_DROP_MAX] (!st_reg.go || mv_rise))
    else $error("Go did not drop after the fall of move.");

  AST_ACCEL_SLOW: assert property (
    (st_reg.go && !st_reg.hs_rew && !cp.fast) |=> st_reg.accel && !st_reg.coast)
    else $error("Drive did not accelerate while the capstan was slow.");

  AST_COAST_FAST: assert property (
    (st_reg.go && !st_reg.hs_rew && cp.fast) |=> st_reg.coast && !st_reg.accel)
    else $error("Drive did not coast while the capstan was fast.");

  AST_FULL_SPEED: assert property ((st_reg.go && st_reg.hs_rew) |=> st_reg.accel)
    else $error("High-speed rewind did not drive at full power.");

  AST_NO_DRIVE_IDLE: assert property (!st_reg.go |=> !st_reg.accel && !st_reg.coast)
    else $error("Drive active without go.");

  AST_PERIOD_STEP: assert property (
    (counting && !closing) |=> st_reg.win == $past(st_reg.win) + 1'b1)
    else $error("A capstan period was not counted.");

  AST_DUTY_NORMAL: assert property (
    (s_close and d_sum <= DW'(capstan_pkg::DUTY_NORMAL_MAX))
      |=> st_reg.duty == capstan_pkg::DUTY_NORMAL)
    else $error("Normal drive share not classed normal.");

  AST_DUTY_MARGINAL: assert property (
    (s_close and d_sum > DW'(capstan_pkg::DUTY_NORMAL_MAX)
      and d_sum <= DW'(capstan_pkg::DUTY_MARGINAL_MAX))
      |=> st_reg.duty == capstan_pkg::DUTY_MARGINAL)
    else $error("Marginal drive share not classed marginal.");

  AST_DUTY_FAILING: assert property (
    (s_close and d_sum > DW'(capstan_pkg::DUTY_MARGINAL_MAX))
      |=> st_reg.duty == capstan_pkg::DUTY_FAILING)
    else $error("Failing drive share not classed failing.");

  AST_SPEED_WRITE: assert property (
    (access && pwrite && !st_reg.err && paddr == capstan_pkg::REG_CTRL)
      |=> cp.speed_sel == $past(pwdata[1:0]))
    else $error("Speed variant write did not take effect.");

  AST_UNMAPPED: assert property (
    (setup && paddr != capstan_pkg::REG_CTRL && paddr != capstan_pkg::REG_STATUS
      && paddr != capstan_pkg::REG_PERIOD && paddr != capstan_pkg::REG_DUTY)
      |=> pslverr && prdata == 32'h0)
    else $error("Unmapped access did not answer with an error.");
endmodule

// [tb/capstan_tach_model.sv]
// Behavioural tachometer that emits squared capstan pulses at a programmed spacing.
`timescale 1ns/1ns
module capstan_tach_model (
  input wire logic pclk,
  input wire logic run,
  input wire logic [31:0] gap,
  output logic tach_in,
  output logic [31:0] n_pulses
);
  logic [31:0] cnt;
  initial begin
    cnt = '0;
    tach_in = 1'b0;
    n_pulses = '0;
  end
  // One pulse at start, then one every gap cycles; the line idles low.
  always @(posedge pclk) begin
    if (!run) begin
      cnt <= '0;
      tach_in <= 1'b0;
    end else begin
      cnt <= (cnt >= gap - 1) ? '0 : cnt + 1;
      tach_in <= (cnt < 3);
      if (cnt == 0) begin
        n_pulses <= n_pulses + 1;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking testbench of the capstan speed regulator.
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tach_in;
  logic move_req = 1'b0;
  logic write_inhibit;
  logic capstan_go;
  logic drive_accel;
  logic drive_coast;
  logic run = 1'b0;
  logic [31:0] gap = 32'h3E8;
  logic [31:0] n_pulses;
  note_t notes[$];
  note_t nt;
  int n_errors = 0;
  int cmp_count = 0;
  int lims[3] = '{250, 150, 94};
  int k;
  int lc;
  always #4 pclk = ~pclk;
  capstan_speed_regulator #(.SHOT_A_CYC(4), .SHOT_B_CYC(2)) u_dut (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tach_in(tach_in), .move_req(move_req), .write_inhibit(write_inhibit),
    .capstan_go(capstan_go), .drive_accel(drive_accel), .drive_coast(drive_coast));
  capstan_tach_model u_tach (.pclk(pclk), .run(run), .gap(gap), .tach_in(tach_in),
    .n_pulses(n_pulses));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic fail(input string msg);
    $display("MISMATCH at %0t: %s", $time, msg);
    n_errors++;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fail(msg);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic e);
    if (!w) begin
      notes.push_back('{d, m, e});
    end
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pulse_pair();
    logic [31:0] p0;
    int n;
    p0 = n_pulses;
    run <= 1'b1;
    n = 0;
    while (n_pulses != p0 + 2 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) begin
      fail("tachometer wait");
    end
    repeat (10) @(posedge pclk);
    run <= 1'b0;
    @(posedge pclk);
  endtask
  // Read results are compared against the oldest note when the access phase completes.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (notes.size() == 0) begin
        fail("read without a note");
      end else begin
        nt = notes.pop_front();
        check(prdata & nt.m, nt.d, "read data");
        check(pslverr, nt.e, "read error");
      end
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(4538));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({write_inhibit, capstan_go, drive_accel, drive_coast}, 4'h8, "reset pins");
    xfer(1'b0, capstan_pkg::REG_CTRL, 32'h0, 32'h7, 1'b0);
    xfer(1'b0, capstan_pkg::REG_STATUS, 32'h8, 32'hF, 1'b0);
    xfer(1'b1, capstan_pkg::REG_STATUS, 32'hFFFFFFFF, 32'h0, 1'b0);
    xfer(1'b0, capstan_pkg::REG_STATUS, 32'h8, 32'hF, 1'b0);
    xfer(1'b0, 12'h010, 32'h0, 32'hFFFFFFFF, 1'b1);
    move_req <= 1'b1;
    k = 0;
    while (capstan_go !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    check({capstan_go, write_inhibit}, 2'h2, "go on move");
    for (int s = 0; s < 3; s++) begin
      lc = lims[s] * 125 / 2;
      xfer(1'b1, capstan_pkg::REG_CTRL, 32'(s), 32'h0, 1'b0);
      xfer(1'b0, capstan_pkg::REG_CTRL, 32'(s), 32'h7, 1'b0);
      for (int f = 0; f < 2; f++) begin
        gap <= 32'(lc * (f ? 105 + $urandom % 15 : 80 + $urandom % 15) / 100);
        pulse_pair();
        check({drive_accel, drive_coast}, f ? 2'h2 : 2'h1, "drive pins");
        xfer(1'b0, capstan_pkg::REG_STATUS, f ? 32'h6 : 32'h5, 32'hF, 1'b0);
        if (f) begin
          xfer(1'b0, capstan_pkg::REG_PERIOD, 32'(lims[s]), 32'h1FF, 1'b0);
        end
      end
    end
    xfer(1'b0, capstan_pkg::REG_DUTY, 32'hC00, 32'h1F00, 1'b0);
    gap <= 32'h40;
    repeat (6) pulse_pair();
    xfer(1'b0, capstan_pkg::REG_DUTY, 32'h0, 32'h1F00, 1'b0);
    xfer(1'b1, capstan_pkg::REG_CTRL, 32'h6, 32'h0, 1'b0);
    gap <= 32'(94 * 125 / 2 * 85 / 100);
    pulse_pair();
    check({drive_accel, drive_coast}, 2'h2, "rewind drive");
    move_req <= 1'b0;
    k = 0;
    while (write_inhibit !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    check(capstan_go, 1'b1, "go before inhibit");
    k = 0;
    while (capstan_go !== 1'b0 && k < 500) begin
      @(posedge pclk);
      k++;
    end
    check(k, capstan_pkg::GO_LAG_CYC, "go lag");
    repeat (2) @(posedge pclk);
    check({drive_accel, drive_coast}, 2'h0, "drive idle");
    xfer(1'b0, capstan_pkg::REG_STATUS, 32'h8, 32'hE, 1'b0);
    repeat (3) @(posedge pclk);
    print_verdict();
  end
  initial begin
    #(8 * 90000);
    fail("watchdog");
    print_verdict();
  end
endmodule
